// >>> hdl/rx_wb_map.vh
// Constants for the receive descriptor status writeback block
`ifndef RX_WB_MAP_VH
`define RX_WB_MAP_VH
// ---------------------------------------------------------------
// Receive status word fields
// ---------------------------------------------------------------
`define SW_OWN 31
`define SW_FILTER_FAIL 30
`define SW_LEN_HI 29
`define SW_LEN_LO 16
`define SW_ERR_SUM 15
`define SW_TRUNC 14
`define SW_SRC_HI 13
`define SW_SRC_LO 12
`define SW_SHORT 11
`define SW_GROUP 10
`define SW_FIRST 9
`define SW_LAST 8
`define SW_OVERSIZE 7
`define SW_LATE_COLL 6
`define SW_CRC 1
`define SW_OVERFLOW 0
// ---------------------------------------------------------------
// Frame source codes
// ---------------------------------------------------------------
`define SRC_LINE 2'h0
`define SRC_INT_LOOP 2'h1
`define SRC_EXT_LOOP 2'h2
// ---------------------------------------------------------------
// Operating mode control fields
// ---------------------------------------------------------------
`define MODE_ACCEPT_ALL 30
`define MODE_OP_HI 11
`define MODE_OP_LO 10
`define MODE_PASS_BAD 3
`define MODE_RESET 32'h00000000
`define MODE_MASK 32'h40000c08
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFF_MODE 8'h00
`define OFF_LAST_STATUS 8'h04
`define OFF_STATE 8'h08
// ---------------------------------------------------------------
// Frame limits in bytes
// ---------------------------------------------------------------
`define MAX_FRAME_LEN 14'h05ee
`define COLL_WINDOW 14'h0040
`endif

// >>> hdl/rx_status_writeback.v
// Receive descriptor status word writeback engine with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "rx_wb_map.vh"

module rx_status_writeback #(
  parameter BUF_W = 11
) (
  input wire ref_clk,
  input wire reset,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_r,
  output reg pready_r,
  output reg pslverr_r,
  // Receive byte stream from the MAC
  input wire rx_byte_valid,
  input wire rx_byte_last,
  input wire rx_collision,
  input wire rx_crc_bad,
  input wire rx_phy_err,
  input wire rx_overflow,
  input wire rx_multicast,
  input wire rx_filter_fail,
  output reg rx_ready_r,
  output reg buf_sel_r,
  // Current descriptor from the fetch logic
  input wire [BUF_W-1:0] buf1_size,
  input wire [BUF_W-1:0] buf2_size,
  input wire next_owned,
  // Status word write to host memory
  output reg wb_valid_r,
  output reg [31:0] wb_data_r,
  input wire wb_ready,
  output reg desc_advance_r,
  output reg frame_drop_r
);

  localparam ST_IDLE = 2'h0;
  localparam ST_RECV = 2'h1;
  localparam ST_TRUNC = 2'h2;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [31:0] mode_r;
  reg [31:0] last_status_r;
  reg [1:0] state_r, state_nxt;
  reg [BUF_W:0] desc_cnt_r, desc_cnt_nxt;
  reg [13:0] len_r, len_nxt;
  reg first_here_r, first_here_nxt;
  reg short_r, short_nxt;
  reg late_r, late_nxt;
  reg oversize_r, oversize_nxt;
  reg wb_valid_nxt;
  reg [31:0] wb_data_nxt;
  reg adv_nxt, drop_nxt;

  wire [BUF_W:0] cap = {1'b0, buf1_size} + {1'b0, buf2_size};
  wire full = (desc_cnt_r == cap);
  wire take = rx_byte_valid && rx_ready_r;
  wire accept_all = mode_r[`MODE_ACCEPT_ALL];
  wire pass_bad = mode_r[`MODE_PASS_BAD];
  wire [1:0] op_mode = mode_r[`MODE_OP_HI:`MODE_OP_LO];
  wire apb_acc = psel && penable && !pready_r;

  // ---------------------------------------------------------------
  // Frame totals including the byte taken at this edge
  // ---------------------------------------------------------------
  // The sequencer clears its counters on the last byte, so the final word reads these
  wire [13:0] len_inc = len_r + 14'h0001;
  wire coll_early = rx_collision && (len_r < `COLL_WINDOW);
  wire coll_late = rx_collision && (len_r >= `COLL_WINDOW);
  wire short_now = short_r || coll_early || (len_inc < `COLL_WINDOW);
  wire late_now = late_r || coll_late;
  wire over_now = oversize_r || (len_r == `MAX_FRAME_LEN);

  // ---------------------------------------------------------------
  // Frame source code from the operating mode
  // ---------------------------------------------------------------
  // Loopback and line traffic are not told apart per frame
  reg [1:0] src_code;
  always @* begin
    case (op_mode)
      2'h0: src_code = `SRC_LINE;
      2'h1: src_code = `SRC_INT_LOOP;
      default: src_code = `SRC_EXT_LOOP;
    endcase
  end

  // ---------------------------------------------------------------
  // Final status word for the last descriptor of a frame
  // ---------------------------------------------------------------
  reg [31:0] final_word;
  reg fin_short, fin_late, fin_over, fin_crc, fin_trunc;
  always @* begin
    fin_trunc = (state_r == ST_TRUNC);
    fin_short = short_now;
    fin_late = late_now;
    fin_over = over_now;
    fin_crc = rx_crc_bad || rx_phy_err;
    final_word = 32'h00000000;
    final_word[`SW_OWN] = 1'b0; // ownership returned here
    final_word[`SW_FILTER_FAIL] = rx_filter_fail && accept_all;
    final_word[`SW_LEN_HI:`SW_LEN_LO] = len_inc;
    final_word[`SW_TRUNC] = fin_trunc;
    final_word[`SW_SRC_HI:`SW_SRC_LO] = src_code;
    final_word[`SW_SHORT] = fin_short;
    final_word[`SW_GROUP] = rx_multicast;
    final_word[`SW_FIRST] = first_here_r;
    final_word[`SW_LAST] = 1'b1;
    final_word[`SW_OVERSIZE] = fin_over;
    final_word[`SW_LATE_COLL] = fin_late;
    final_word[`SW_CRC] = fin_crc;
    final_word[`SW_OVERFLOW] = rx_overflow;
    final_word[`SW_ERR_SUM] = rx_overflow || fin_crc || fin_late || fin_over ||
      fin_short || fin_trunc;
  end

  // Word for a filled descriptor that is not the frame's last
  reg [31:0] mid_word;
  always @* begin
    mid_word = 32'h00000000;
    mid_word[`SW_OWN] = 1'b0;
    mid_word[`SW_LEN_HI:`SW_LEN_LO] = len_r;
    mid_word[`SW_FIRST] = first_here_r;
  end

  // Runt that never left this descriptor and may not be passed on
  wire runt_drop = fin_short && !pass_bad && first_here_r && !fin_trunc;

  // ---------------------------------------------------------------
  // Receive sequencing
  // ---------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    desc_cnt_nxt = desc_cnt_r;
    len_nxt = len_r;
    first_here_nxt = first_here_r;
    short_nxt = short_r;
    late_nxt = late_r;
    oversize_nxt = oversize_r;
    wb_valid_nxt = wb_valid_r && !wb_ready;
    wb_data_nxt = wb_data_r;
    adv_nxt = 1'b0;
    drop_nxt = 1'b0;
    if (take) begin
      len_nxt = len_r + 14'h0001;
      if (len_r == `MAX_FRAME_LEN)
        oversize_nxt = 1'b1; // flag only, bytes still stored
      if (rx_collision && (len_r < `COLL_WINDOW))
        short_nxt = 1'b1;
      if (rx_collision && (len_r >= `COLL_WINDOW))
        late_nxt = 1'b1;
      if (state_r != ST_TRUNC)
        desc_cnt_nxt = desc_cnt_r + {{BUF_W{1'b0}}, 1'b1};
      if (state_r == ST_IDLE)
        state_nxt = ST_RECV;
      if (rx_byte_last) begin
        state_nxt = ST_IDLE;
        len_nxt = 14'h0000;
        short_nxt = 1'b0;
        late_nxt = 1'b0;
        oversize_nxt = 1'b0;
        first_here_nxt = 1'b1;
        // A runt that never left this descriptor is simply reused
        if (runt_drop) begin
          drop_nxt = 1'b1;
          desc_cnt_nxt = {(BUF_W+1){1'b0}};
        end else begin
          wb_valid_nxt = 1'b1; // status and ownership in one write
          wb_data_nxt = final_word;
          adv_nxt = 1'b1;
          desc_cnt_nxt = {(BUF_W+1){1'b0}};
        end
      end
    end else if (rx_byte_valid && !wb_valid_r && state_r != ST_TRUNC && full) begin
      if (next_owned) begin
        // Zero-size descriptor holds no byte, so the start moves on
        wb_valid_nxt = 1'b1;
        wb_data_nxt = (desc_cnt_r == {(BUF_W+1){1'b0}}) ? 32'h00000000 : mid_word;
        adv_nxt = 1'b1;
        desc_cnt_nxt = {(BUF_W+1){1'b0}};
        if (desc_cnt_r != {(BUF_W+1){1'b0}})
          first_here_nxt = 1'b0;
      end else begin
        state_nxt = ST_TRUNC; // rest of frame discarded
      end
    end
  end

  // Stall the MAC while a write waits or the descriptor is full
  wire ready_nxt = !wb_valid_nxt && ((state_nxt == ST_TRUNC) || (desc_cnt_nxt != cap));

  always @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      desc_cnt_r <= {(BUF_W+1){1'b0}};
      len_r <= 14'h0000;
      first_here_r <= 1'b1;
      short_r <= 1'b0;
      late_r <= 1'b0;
      oversize_r <= 1'b0;
      wb_valid_r <= 1'b0;
      wb_data_r <= 32'h00000000;
      desc_advance_r <= 1'b0;
      frame_drop_r <= 1'b0;
      rx_ready_r <= 1'b0;
      buf_sel_r <= 1'b0;
      last_status_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      desc_cnt_r <= desc_cnt_nxt;
      len_r <= len_nxt;
      first_here_r <= first_here_nxt;
      short_r <= short_nxt;
      late_r <= late_nxt;
      oversize_r <= oversize_nxt;
      wb_valid_r <= wb_valid_nxt;
      wb_data_r <= wb_data_nxt;
      desc_advance_r <= adv_nxt;
      frame_drop_r <= drop_nxt;
      rx_ready_r <= ready_nxt;
      // Next byte lands in buffer two once buffer one is used up
      buf_sel_r <= (desc_cnt_nxt >= {1'b0, buf1_size});
      if (wb_valid_r && wb_ready)
        last_status_r <= wb_data_r;
    end
  end

  // ---------------------------------------------------------------
  // APB register access
  // ---------------------------------------------------------------
  // One wait state keeps read data registered
  reg [31:0] rdata_nxt;
  reg err_nxt;
  always @* begin
    rdata_nxt = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      `OFF_MODE: rdata_nxt = mode_r;
      `OFF_LAST_STATUS: rdata_nxt = last_status_r;
      `OFF_STATE: rdata_nxt = {16'h0000, wb_valid_r, rx_ready_r, state_r, len_r[11:0]};
      default: err_nxt = 1'b1;
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      mode_r <= `MODE_RESET;
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_acc;
      prdata_r <= (apb_acc && !pwrite) ? rdata_nxt : 32'h00000000;
      pslverr_r <= apb_acc && err_nxt;
      if (psel && penable && pready_r && pwrite && paddr == `OFF_MODE)
        mode_r <= pwdata & `MODE_MASK;
    end
  end

endmodule // rx_status_writeback
`default_nettype wire

// >>> tb/rx_wb_monitor.sv
// Assertion checker for the receive status writeback block
`timescale 1ns/1ps
`default_nettype none
module rx_wb_monitor (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready_r,
  input wire logic rx_byte_valid,
  input wire logic rx_byte_last,
  input wire logic rx_ready_r,
  input wire logic wb_valid_r,
  input wire logic [31:0] wb_data_r,
  input wire logic wb_ready,
  input wire logic desc_advance_r,
  input wire logic frame_drop_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_acc;
    psel && penable && !pready_r;
  endsequence
  sequence s_end;
    rx_byte_valid && rx_ready_r && rx_byte_last;
  endsequence
  property p_apb; s_acc |=> pready_r; endproperty
  property p_pulse; pready_r |=> !pready_r; endproperty
  property p_own; wb_valid_r |-> !wb_data_r[31]; endproperty
  property p_sum;
    wb_valid_r |-> wb_data_r[15] == |{wb_data_r[14], wb_data_r[11], wb_data_r[7:6], wb_data_r[1:0]};
  endproperty
  property p_src; wb_valid_r |-> wb_data_r[13:12] != 2'h3; endproperty
  property p_hold;
    wb_valid_r && !wb_ready |=> wb_valid_r && $stable(wb_data_r);
  endproperty
  property p_last; s_end |=> ##[0:1] (wb_valid_r || frame_drop_r); endproperty
  property p_adv; $rose(wb_valid_r) |-> desc_advance_r; endproperty
  property p_big;
    wb_valid_r && wb_data_r[8] && !wb_data_r[14] |-> wb_data_r[7] == (wb_data_r[29:16] > 1518);
  endproperty
  a_apb: assert property (p_apb) else $error("no answer one cycle after access");
  a_pulse: assert property (p_pulse) else $error("ready held over one cycle");
  a_own: assert property (p_own) else $error("ownership left set");
  a_sum: assert property (p_sum) else $error("error summary wrong");
  a_src: assert property (p_src) else $error("reserved source code");
  a_hold: assert property (p_hold) else $error("status changed while pending");
  a_last: assert property (p_last) else $error("no status after last byte");
  a_adv: assert property (p_adv) else $error("descriptor not advanced");
  a_big: assert property (p_big) else $error("oversize flag wrong");
endmodule // rx_wb_monitor
bind rx_status_writeback rx_wb_monitor mon (.ref_clk(ref_clk), .reset(reset), .psel(psel),
  .penable(penable), .pready_r(pready_r), .rx_byte_valid(rx_byte_valid),
  .rx_byte_last(rx_byte_last), .rx_ready_r(rx_ready_r), .wb_valid_r(wb_valid_r),
  .wb_data_r(wb_data_r), .wb_ready(wb_ready), .desc_advance_r(desc_advance_r),
  .frame_drop_r(frame_drop_r));
`default_nettype wire

// >>> tb/host_mem_model.sv
// Host memory model taking status word writes with random stalls
`timescale 1ns/1ps
`default_nettype none
module host_mem_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_valid_r,
  input wire logic [31:0] wb_data_r,
  output logic wb_ready
);
  integer seed = 32'hc49d35a4;
  logic [31:0] mem [0:15];
  logic [3:0] ptr;
  // Stalls often so the writer must hold its word
  always @(posedge ref_clk) begin
    if (reset) begin
      wb_ready <= 1'b0;
      ptr <= 4'h0;
    end else begin
      wb_ready <= ($random(seed) % 3) == 0;
      // Whole word kept; fields are judged whether or not last-buffer is set
      if (wb_valid_r && wb_ready) begin
        mem[ptr] <= wb_data_r;
        ptr <= ptr + 4'h1;
      end
    end
  end
endmodule // host_mem_model
`default_nettype wire

// >>> tb/rx_status_writeback_test.sv
// Self-checking bench for the receive status writeback block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module rx_status_writeback_test;
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, wb_ready;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata_r, wb_data_r, q, r, w_exp;
  logic pready_r, pslverr_r, rx_ready_r, wb_valid_r, e, aa, pb, tr;
  logic rx_collision = 0, next_owned = 1;
  wire frame_drop_r;
  logic rx_byte_valid = 0, rx_byte_last = 0, rx_crc_bad = 0, rx_phy_err = 0;
  logic rx_overflow = 0, rx_multicast = 0, rx_filter_fail = 0;
  logic [10:0] buf1_size = 11'h3e8, buf2_size = 11'h3e8;
  integer seed = 32'hc49d35a4;
  int bad_count = 0, cmp_count = 0, t, n, k, col;
  logic [31:0] q_exp [$];
  always #5 ref_clk = ~ref_clk;
  rx_status_writeback uut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .rx_byte_valid(rx_byte_valid),
    .rx_byte_last(rx_byte_last), .rx_collision(rx_collision), .rx_crc_bad(rx_crc_bad),
    .rx_phy_err(rx_phy_err), .rx_overflow(rx_overflow), .rx_multicast(rx_multicast),
    .rx_filter_fail(rx_filter_fail), .rx_ready_r(rx_ready_r), .buf_sel_r(),
    .buf1_size(buf1_size), .buf2_size(buf2_size), .next_owned(next_owned),
    .wb_valid_r(wb_valid_r), .wb_data_r(wb_data_r), .wb_ready(wb_ready), .desc_advance_r(),
    .frame_drop_r(frame_drop_r));
  host_mem_model host (.ref_clk(ref_clk), .reset(reset), .wb_valid_r(wb_valid_r),
    .wb_data_r(wb_data_r), .wb_ready(wb_ready));
  task complete_run;
    $display("compares %0d bad %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task fail;
    bad_count++;
    complete_run;
  endtask
  function automatic [31:0] exp_word(input int n, input aa, input [1:0] op, input [4:0] f,
    input int col, input tr);
    logic s, o, c, l;
    s = n < 64 || (col >= 0 && col < 64);
    l = col >= 64;
    o = n > 1518;
    c = f[2] | f[3];
    return {1'b0, f[0] & aa, n[13:0], f[4] | c | o | s | l | tr, tr, (op == 2'h3) ? 2'h2 : op,
      s, f[1], 2'h3, o, l, 4'h0, c, f[4]};
  endfunction
  task automatic apb(input w, input [7:0] a, input [31:0] d, output [31:0] rd, output er);
    int j;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    j = 0;
    do begin @(posedge ref_clk); j++; end while (!pready_r && j < 99);
    if (j >= 99) fail;
    rd = prdata_r;
    er = pslverr_r;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic frame(input int len, input [4:0] f, input int cb);
    int i, j;
    for (i = 0; i < len; i++) begin
      rx_byte_valid <= 1;
      rx_collision <= i == cb;
      rx_byte_last <= i == len - 1;
      {rx_overflow, rx_phy_err, rx_crc_bad, rx_multicast, rx_filter_fail} <= (i == len - 1) ? f : 0;
      j = 0;
      do begin @(posedge ref_clk); j++; end while (!rx_ready_r && j < 9999);
      if (j >= 9999) fail;
    end
    rx_byte_valid <= 0;
    rx_byte_last <= 0;
    rx_collision <= 0;
  endtask
  // Drops are queued as all ones so order against writes is kept
  always @(posedge ref_clk) begin
    if (!reset && (wb_valid_r && wb_ready || frame_drop_r)) begin
      w_exp = q_exp.pop_front();
      `CHK("status", w_exp, frame_drop_r ? 32'hffffffff : wb_data_r)
    end
  end
  initial begin
    #900000;
    fail;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk);
    apb(1, 8'h00, 32'hffffffff, q, e);
    apb(0, 8'h00, 0, q, e);
    `CHK("mode", 32'h40000c08, q)
    apb(0, 8'h0c, 0, q, e);
    `CHK("slverr", 1'b1, e)
    for (t = 0; t < 8; t++) begin
      aa = $random(seed);
      pb = t != 5;
      tr = t == 6;
      col = (t == 4) ? 10 : (t == 7) ? 80 : -1;
      apb(1, 8'h00, {1'b0, aa, 18'h0, t[1:0], 6'h0, pb, 3'h0}, q, e);
      n = (t < 4) ? 64 + t * 500 : (t == 5) ? 20 : 100;
      r = $random(seed);
      // Small descriptor with the next one not owned forces truncation
      if (tr) begin
        buf1_size <= 11'h008;
        buf2_size <= 11'h008;
        next_owned <= 0;
      end
      q_exp.push_back(pb ? exp_word(n, aa, t[1:0], r[4:0], col, tr) : 32'hffffffff);
      frame(n, r[4:0], col);
      buf1_size <= 11'h3e8;
      buf2_size <= 11'h3e8;
      next_owned <= 1;
      $display("test %0d done", t);
    end
    k = 0;
    while (q_exp.size() != 0 && k < 9999) begin @(posedge ref_clk); k++; end
    if (k >= 9999) bad_count++;
    complete_run;
  end
endmodule // rx_status_writeback_test
`default_nettype wire
